// file: rtl/dlt_params.svh
// Register indices, field positions, reset values and counts
`ifndef DLT_PARAMS_SVH
`define DLT_PARAMS_SVH
//****************************************************************
// How it works
// - 13-bit: low five bits 0..31, then clear and high byte increments.
// - 13-bit: low bits 0..4 and all high bits count.
// - 13-bit: 0x1FFF rolls to zero and sets overflow flag.
// - Timers zero/one count only with run bit (control bits 4, 6), except timer one while zero is split.
// - Gate bit (mode bits 7, 3) adds the interrupt pin level.
// - Gate set needs pin high too; gate clear ignores pin.
// - Select bit (mode bits 6, 2): clock or external events.
// - Timer counts clock or clock/12; counter counts pin falls.
// - Mode 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split.
// - Overflow flag sets on overflow, clears on vectoring.
// - 16-bit: low byte carries into high; 0xFFFF rolls to zero.
// - 8-bit reload: low byte reloads from high byte on overflow.
// - Split: zero low uses run/flag zero, high uses run/flag one.
// - Zero split: timer one still counts but raises no interrupt.
// - Timer one in split mode stops and holds its count.
// - Timer two overflow flag needs routing bits zero; software clears.
// - Writing one to timer two flags raises their request.
// - Enabled trigger fall sets external flag; disabled, no effect.
// - Timer two counts only while its run bit is one.
// - Timer two: clock or clock/12, or count pin falls.
// - Either routing bit disables capture; overflow reloads.
// - Plain mode counts 0000h..FFFFh, rolls, sets overflow flag.
// - Capture: trigger fall copies count to capture bytes, sets flag.
// - Reload: overflow loads reload bytes, sets flag same cycle.
// - Reload with enable: trigger fall reloads, sets external flag.
//****************************************************************
`define DLT_IDX_TCTL   8'h88
`define DLT_IDX_TMODE  8'h89
`define DLT_IDX_T0LO   8'h8A
`define DLT_IDX_T1LO   8'h8B
`define DLT_IDX_T0HI   8'h8C
`define DLT_IDX_T1HI   8'h8D
`define DLT_IDX_CKSEL  8'h8E
`define DLT_IDX_T2CTL  8'hC8
`define DLT_IDX_CAPLO  8'hCA
`define DLT_IDX_CAPHI  8'hCB
`define DLT_IDX_T2LO   8'hCC
`define DLT_IDX_T2HI   8'hCD
`define DLT_TC_FLAG1   7
`define DLT_TC_RUN1    6
`define DLT_TC_FLAG0   5
`define DLT_TC_RUN0    4
`define DLT_TM_GATE1   7
`define DLT_TM_SRC1    6
`define DLT_TM_GATE0   3
`define DLT_TM_SRC0    2
`define DLT_CK_PRE0    3
`define DLT_CK_PRE1    4
`define DLT_CK_PRE2    5
`define DLT_T2_OVF     7
`define DLT_T2_EXT     6
`define DLT_T2_RXR     5
`define DLT_T2_TXR     4
`define DLT_T2_TRIGEN  3
`define DLT_T2_RUN     2
`define DLT_T2_SRC     1
`define DLT_T2_CAPSEL  0
`define DLT_RST_BYTE   8'h00
`define DLT_RST_WORD   16'h0000
`define DLT_PRESCALE   4'hC
`endif

// file: rtl/dlt_pkg.sv
// Types shared by the timer block
package dlt_pkg;
  // Mode field of each legacy timer, in ascending encoding
  typedef enum logic [1:0] {
    DLT_MODE_13BIT,
    DLT_MODE_16BIT,
    DLT_MODE_RELOAD,
    DLT_MODE_SPLIT
  } dlt_mode_t;
endpackage

// file: rtl/dlt_fall_det.sv
// Falling edge detector for a group of synchronous input pins
`timescale 1ns/100ps
`default_nettype none
module dlt_fall_det #(
  parameter int N = 4
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic [N-1:0] pins_in,
  output logic      [N-1:0] fall_out
);
  logic [N-1:0] cur_q;
  logic [N-1:0] prev_q;

  // Two successive samples; reset to high so no false edge at start
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cur_q  <= '1;
      prev_q <= '1;
    end else begin
      cur_q  <= pins_in;
      prev_q <= cur_q;
    end
  end

  // High then low marks one fall, one cycle long
  assign fall_out = prev_q & ~cur_q;
endmodule
`default_nettype wire

// file: rtl/dlt_timers.sv
// Two legacy timers and a capture/reload timer behind an APB slave
`timescale 1ns/100ps
`default_nettype none
`include "dlt_params.svh"
module dlt_timers
  import dlt_pkg::*;
#(
  parameter logic [3:0] PRESCALE = `DLT_PRESCALE
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_irq_pin_zero_in,
  input  wire logic        ext_irq_pin_one_in,
  input  wire logic        count_pin_zero_in,
  input  wire logic        count_pin_one_in,
  input  wire logic        timer_two_count_pin_in,
  input  wire logic        trigger_pin_in,
  input  wire logic        vector_ack_zero_in,
  input  wire logic        vector_ack_one_in,
  output logic             overflow_flag_zero_out,
  output logic             overflow_flag_one_out,
  output logic             timer_two_overflow_flag_out,
  output logic             timer_two_external_flag_out,
  output logic             timer_one_overflow_pulse_out
);
  //****************************************************************
  // Declarations
  //****************************************************************
  logic [3:0]  pre_q;
  logic        div_en;
  logic [3:0]  fall;
  logic [7:0]  timer_mode_reg_q;
  logic [7:0]  clock_select_reg_q;
  logic        run_bit_zero_q;
  logic        run_bit_one_q;
  logic        overflow_flag_zero_q;
  logic        overflow_flag_one_q;
  logic [7:0]  t0_lo_q;
  logic [7:0]  t0_hi_q;
  logic [7:0]  t1_lo_q;
  logic [7:0]  t1_hi_q;
  logic [5:0]  t2_ctl_q;
  logic        t2_ovf_q;
  logic        t2_ext_q;
  logic [15:0] t2_cnt_q;
  logic [15:0] t2_cnt_d;
  logic [15:0] cap_q;
  logic [15:0] cap_d;
  logic        pulse_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0]  idx;
  logic        hit;
  logic        acc;
  logic        wr;
  logic [7:0]  wdat;
  logic [7:0]  rd_d;
  dlt_mode_t   mode0;
  dlt_mode_t   mode1;
  logic        split0;
  logic        src0;
  logic        src1;
  logic        src2;
  logic        tick0;
  logic        tick0_hi;
  logic        tick1;
  logic        tick2;
  logic [16:0] step0;
  logic [16:0] step1;
  logic        set0;
  logic        set1;
  logic        route;
  logic        wrap2;
  logic        trig2;
  logic        reload2;
  logic        capture2;

  //****************************************************************
  // Helpers
  //****************************************************************
  // One count step of a legacy timer; bit 16 is the overflow
  function automatic logic [16:0] dlt_step(input dlt_mode_t m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      DLT_MODE_13BIT: begin
        // Upper three low bits are left alone, software masks them
        if (lo[4:0] == 5'h1F) begin
          r[4:0]  = 5'h00;
          r[15:8] = hi + 8'h01;
          r[16]   = (hi == 8'hFF);
        end else begin
          r[4:0] = lo[4:0] + 5'h01;
        end
      end
      DLT_MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      DLT_MODE_RELOAD: begin
        if (lo == 8'hFF) begin
          r = {1'b1, hi, hi};
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
      default: begin
        // Split low byte: plain 8-bit wrap
        if (lo == 8'hFF) begin
          r = {1'b1, hi, 8'h00};
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
    endcase
    return r;
  endfunction

  // True for every index the block answers
  function automatic logic dlt_mapped(input logic [7:0] i);
    case (i)
      `DLT_IDX_TCTL, `DLT_IDX_TMODE, `DLT_IDX_T0LO, `DLT_IDX_T1LO,
      `DLT_IDX_T0HI, `DLT_IDX_T1HI, `DLT_IDX_CKSEL, `DLT_IDX_T2CTL,
      `DLT_IDX_CAPLO, `DLT_IDX_CAPHI, `DLT_IDX_T2LO,
      `DLT_IDX_T2HI: dlt_mapped = 1'b1;
      default:       dlt_mapped = 1'b0;
    endcase
  endfunction

  //****************************************************************
  // Pin edges and prescaler
  //****************************************************************
  dlt_fall_det #(
    .N (4)
  ) u_fall (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pins_in    ({trigger_pin_in, timer_two_count_pin_in,
                  count_pin_one_in, count_pin_zero_in}),
    .fall_out   (fall)
  );

  // Divide by twelve gives a one-cycle enable, not a new clock
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pre_q <= 4'h0;
    end else if (div_en) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end
  assign div_en = (pre_q == PRESCALE - 4'h1);

  //****************************************************************
  // APB slave
  //****************************************************************
  // Word index; unaligned or out-of-range addresses miss
  assign idx  = paddr_in[9:2];
  assign hit  = (paddr_in[11:10] == 2'b00) && (paddr_in[1:0] == 2'b00) && dlt_mapped(idx);
  assign acc  = psel_in && penable_in;
  assign wr   = acc && pready_q && pwrite_in && hit && pstrb_in[0];
  assign wdat = pwdata_in[7:0];

  // One wait state keeps read data and ready straight from flops
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !hit;
      if (acc && !pready_q && !pwrite_in && hit) begin
        prdata_q <= {24'h00_0000, rd_d};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Read view; low half of the control register belongs elsewhere
  always_comb begin
    case (idx)
      `DLT_IDX_TCTL:  rd_d = {overflow_flag_one_q, run_bit_one_q,
                              overflow_flag_zero_q, run_bit_zero_q, 4'h0};
      `DLT_IDX_TMODE: rd_d = timer_mode_reg_q;
      `DLT_IDX_T0LO:  rd_d = t0_lo_q;
      `DLT_IDX_T1LO:  rd_d = t1_lo_q;
      `DLT_IDX_T0HI:  rd_d = t0_hi_q;
      `DLT_IDX_T1HI:  rd_d = t1_hi_q;
      `DLT_IDX_CKSEL: rd_d = clock_select_reg_q;
      `DLT_IDX_T2CTL: rd_d = {t2_ovf_q, t2_ext_q, t2_ctl_q};
      `DLT_IDX_CAPLO: rd_d = cap_q[7:0];
      `DLT_IDX_CAPHI: rd_d = cap_q[15:8];
      `DLT_IDX_T2LO:  rd_d = t2_cnt_q[7:0];
      `DLT_IDX_T2HI:  rd_d = t2_cnt_q[15:8];
      default:        rd_d = 8'h00;
    endcase
  end

  //****************************************************************
  // Configuration registers
  //****************************************************************
  // Mode, clock select and run bits
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      timer_mode_reg_q   <= `DLT_RST_BYTE;
      clock_select_reg_q <= `DLT_RST_BYTE;
      run_bit_zero_q     <= 1'b0;
      run_bit_one_q      <= 1'b0;
      t2_ctl_q           <= 6'h00;
    end else if (wr) begin
      if (idx == `DLT_IDX_TMODE) timer_mode_reg_q <= wdat;
      if (idx == `DLT_IDX_CKSEL) clock_select_reg_q <= wdat;
      if (idx == `DLT_IDX_T2CTL) t2_ctl_q <= wdat[5:0];
      if (idx == `DLT_IDX_TCTL) begin
        run_bit_zero_q <= wdat[`DLT_TC_RUN0];
        run_bit_one_q  <= wdat[`DLT_TC_RUN1];
      end
    end
  end

  //****************************************************************
  // Legacy timers zero and one
  //****************************************************************
  // Enable terms: run bit, optional gate pin, then source select
  assign mode0  = dlt_mode_t'(timer_mode_reg_q[1:0]);
  assign mode1  = dlt_mode_t'(timer_mode_reg_q[5:4]);
  assign split0 = (mode0 == DLT_MODE_SPLIT);
  assign src0   = clock_select_reg_q[`DLT_CK_PRE0] | div_en;
  assign src1   = clock_select_reg_q[`DLT_CK_PRE1] | div_en;
  assign tick0  = run_bit_zero_q
                && (!timer_mode_reg_q[`DLT_TM_GATE0] || ext_irq_pin_zero_in)
                && (timer_mode_reg_q[`DLT_TM_SRC0] ? fall[0] : src0);
  // Split high byte borrows run bit one and always counts clocks
  assign tick0_hi = split0 && run_bit_one_q && src0;
  // With run bit one lent to timer zero, timer one runs on its gate alone
  assign tick1  = (split0 || run_bit_one_q)
                && (mode1 != DLT_MODE_SPLIT)
                && (!timer_mode_reg_q[`DLT_TM_GATE1] || ext_irq_pin_one_in)
                && (timer_mode_reg_q[`DLT_TM_SRC1] ? fall[1] : src1);
  assign step0  = dlt_step(mode0, t0_lo_q, t0_hi_q);
  assign step1  = dlt_step(mode1, t1_lo_q, t1_hi_q);
  assign set0   = tick0 && step0[16];
  assign set1   = split0 ? (tick0_hi && t0_hi_q == 8'hFF)
                         : (tick1 && step1[16]);

  // Timer zero bytes; a software write beats a count step
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      t0_lo_q <= `DLT_RST_BYTE;
      t0_hi_q <= `DLT_RST_BYTE;
    end else begin
      if (wr && idx == `DLT_IDX_T0LO) begin
        t0_lo_q <= wdat;
      end else if (tick0) begin
        t0_lo_q <= step0[7:0];
      end
      if (wr && idx == `DLT_IDX_T0HI) begin
        t0_hi_q <= wdat;
      end else if (tick0_hi) begin
        t0_hi_q <= t0_hi_q + 8'h01;
      end else if (tick0 && !split0) begin
        t0_hi_q <= step0[15:8];
      end
    end
  end

  // Timer one bytes; in its own split mode it simply holds
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      t1_lo_q <= `DLT_RST_BYTE;
      t1_hi_q <= `DLT_RST_BYTE;
    end else begin
      if (wr && idx == `DLT_IDX_T1LO) begin
        t1_lo_q <= wdat;
      end else if (tick1) begin
        t1_lo_q <= step1[7:0];
      end
      if (wr && idx == `DLT_IDX_T1HI) begin
        t1_hi_q <= wdat;
      end else if (tick1) begin
        t1_hi_q <= step1[15:8];
      end
    end
  end

  // Overflow flags: set beats a vector clear or a software write
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      overflow_flag_zero_q <= 1'b0;
      overflow_flag_one_q  <= 1'b0;
    end else begin
      if (set0) begin
        overflow_flag_zero_q <= 1'b1;
      end else if (wr && idx == `DLT_IDX_TCTL) begin
        overflow_flag_zero_q <= wdat[`DLT_TC_FLAG0];
      end else if (vector_ack_zero_in) begin
        overflow_flag_zero_q <= 1'b0;
      end
      if (set1) begin
        overflow_flag_one_q <= 1'b1;
      end else if (wr && idx == `DLT_IDX_TCTL) begin
        overflow_flag_one_q <= wdat[`DLT_TC_FLAG1];
      end else if (vector_ack_one_in) begin
        overflow_flag_one_q <= 1'b0;
      end
    end
  end

  // Baud source keeps ticking even when its flag is lent away
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= tick1 && step1[16];
    end
  end

  //****************************************************************
  // Timer two
  //****************************************************************
  assign route    = t2_ctl_q[`DLT_T2_RXR] | t2_ctl_q[`DLT_T2_TXR];
  assign src2     = t2_ctl_q[`DLT_T2_SRC] ? fall[2]
                  : (clock_select_reg_q[`DLT_CK_PRE2] | div_en);
  assign tick2    = t2_ctl_q[`DLT_T2_RUN] && src2;
  assign wrap2    = tick2 && (t2_cnt_q == 16'hFFFF);
  assign trig2    = t2_ctl_q[`DLT_T2_TRIGEN] && fall[3];
  // Routing bits force reload on overflow and shut capture off
  assign reload2  = (wrap2 && (route || !t2_ctl_q[`DLT_T2_CAPSEL]))
                 || (trig2 && !t2_ctl_q[`DLT_T2_CAPSEL]);
  assign capture2 = trig2 && t2_ctl_q[`DLT_T2_CAPSEL] && !route;

  // Next count: reload, else step, then byte writes on top
  always_comb begin
    t2_cnt_d = t2_cnt_q;
    if (reload2) begin
      t2_cnt_d = cap_q;
    end else if (tick2) begin
      t2_cnt_d = t2_cnt_q + 16'h0001;
    end
    if (wr && idx == `DLT_IDX_T2LO) t2_cnt_d[7:0] = wdat;
    if (wr && idx == `DLT_IDX_T2HI) t2_cnt_d[15:8] = wdat;
  end

  // Capture bytes double as reload bytes
  always_comb begin
    cap_d = cap_q;
    if (capture2) cap_d = t2_cnt_q;
    if (wr && idx == `DLT_IDX_CAPLO) cap_d[7:0] = wdat;
    if (wr && idx == `DLT_IDX_CAPHI) cap_d[15:8] = wdat;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      t2_cnt_q <= `DLT_RST_WORD;
      cap_q    <= `DLT_RST_WORD;
    end else begin
      t2_cnt_q <= t2_cnt_d;
      cap_q    <= cap_d;
    end
  end

  // Timer two flags: only software clears, writing one forces them
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      t2_ovf_q <= 1'b0;
      t2_ext_q <= 1'b0;
    end else begin
      if (wrap2 && !route) begin
        t2_ovf_q <= 1'b1;
      end else if (wr && idx == `DLT_IDX_T2CTL) begin
        t2_ovf_q <= wdat[`DLT_T2_OVF];
      end
      if (trig2) begin
        t2_ext_q <= 1'b1;
      end else if (wr && idx == `DLT_IDX_T2CTL) begin
        t2_ext_q <= wdat[`DLT_T2_EXT];
      end
    end
  end

  //****************************************************************
  // Outputs
  //****************************************************************
  assign prdata_out                   = prdata_q;
  assign pready_out                   = pready_q;
  assign pslverr_out                  = pslverr_q;
  assign overflow_flag_zero_out       = overflow_flag_zero_q;
  assign overflow_flag_one_out        = overflow_flag_one_q;
  assign timer_two_overflow_flag_out  = t2_ovf_q;
  assign timer_two_external_flag_out  = t2_ext_q;
  assign timer_one_overflow_pulse_out = pulse_q;
endmodule
`default_nettype wire

// file: test/dlt_pin_model.sv
// Far-side model of the gate, count and trigger pins
`timescale 1ns/100ps
`default_nettype none
module dlt_pin_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] gate_req_in,
  input  wire logic [3:0] fall_req_in,
  output logic      [1:0] gate_out,
  output logic      [3:0] pins_out
);
  // Pins idle high; a one-cycle request gives one low cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pins_out <= 4'hF;
    end else begin
      pins_out <= ~fall_req_in;
    end
  end
  // Gate levels follow the bench one clock late
  always_ff @(posedge clk_sys_in) begin
    gate_out <= gate_req_in;
  end
endmodule
`default_nettype wire

// file: test/dlt_timers_chk.sv
// Concurrent checks on the timer block's bus and flag ports
`timescale 1ns/100ps
`default_nettype none
module dlt_timers_chk (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        vector_ack_zero_in,
  input wire logic        vector_ack_one_in,
  input wire logic        overflow_flag_zero_out,
  input wire logic        overflow_flag_one_out,
  input wire logic        timer_two_overflow_flag_out,
  input wire logic        timer_two_external_flag_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Completed write; flags may drop one or two edges later
  logic wr_done;
  assign wr_done = psel_in & penable_in & pwrite_in & pready_out;
  //****************************************************************
  // Bus timing and flag clearing
  //****************************************************************
  property p_one_wait; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_rdy_pulse; pready_out |=> !pready_out; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_cause; pready_out |-> $past(psel_in && penable_in); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
  property p_err_rdy; pslverr_out |-> pready_out; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_idle; !(pready_out && !pwrite_in) |-> prdata_out == 32'h00000000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_fl0; $fell(overflow_flag_zero_out) |-> $past(vector_ack_zero_in) || $past(wr_done)
    || $past(vector_ack_zero_in, 2) || $past(wr_done, 2); endproperty
  a_fl0: assert property (p_fl0) else $error("flag zero cleared without cause");
  property p_fl1; $fell(overflow_flag_one_out) |-> $past(vector_ack_one_in) || $past(wr_done)
    || $past(vector_ack_one_in, 2) || $past(wr_done, 2); endproperty
  a_fl1: assert property (p_fl1) else $error("flag one cleared without cause");
  property p_t2ovf; $fell(timer_two_overflow_flag_out) |-> $past(wr_done) || $past(wr_done, 2); endproperty
  a_t2ovf: assert property (p_t2ovf) else $error("t2 ovf cleared");
  property p_t2ext; $fell(timer_two_external_flag_out) |-> $past(wr_done) || $past(wr_done, 2); endproperty
  a_t2ext: assert property (p_t2ext) else $error("t2 ext cleared");
  c_err: cover property (pslverr_out);
  c_ext: cover property ($rose(timer_two_external_flag_out));
  c_fl1: cover property ($rose(overflow_flag_one_out));
endmodule
bind dlt_timers dlt_timers_chk u_chk (.*);
`default_nettype wire

// file: test/dlt_timers_tb_top.sv
// Self-checking bench of the timer block
`timescale 1ns/100ps
`default_nettype none
`include "dlt_params.svh"
module dlt_timers_tb_top;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rdv;
  logic        pready_out, pslverr_out, errv;
  logic        vector_ack_zero_in = 1'b0, vector_ack_one_in = 1'b0;
  logic        overflow_flag_zero_out, overflow_flag_one_out, timer_one_overflow_pulse_out;
  logic        timer_two_overflow_flag_out, timer_two_external_flag_out;
  logic [1:0]  gate_req = 2'b00, gate;
  logic [3:0]  fall_req = 4'h0, pins;
  int          err_count = 0, compares = 0, cyc = 0;
  // Rows: index, write data, expected read, expected error
  logic [24:0] rows [11] = '{{`DLT_IDX_T0LO, 8'hA5, 8'hA5, 1'b0}, {`DLT_IDX_T1LO, 8'h5A, 8'h5A, 1'b0},
    {`DLT_IDX_T0HI, 8'h3C, 8'h3C, 1'b0}, {`DLT_IDX_T1HI, 8'hC3, 8'hC3, 1'b0},
    {`DLT_IDX_CAPLO, 8'h81, 8'h81, 1'b0}, {`DLT_IDX_CAPHI, 8'h7E, 8'h7E, 1'b0},
    {`DLT_IDX_T2LO, 8'h11, 8'h11, 1'b0}, {`DLT_IDX_T2HI, 8'hEE, 8'hEE, 1'b0},
    {`DLT_IDX_CKSEL, 8'h38, 8'h38, 1'b0}, {`DLT_IDX_TCTL, 8'h0F, 8'h00, 1'b0}, {8'h90, 8'hFF, 8'h00, 1'b1}};
  dlt_timers #(.PRESCALE(4'h2)) dut (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in(4'hF), .prdata_out, .pready_out, .pslverr_out,
    .ext_irq_pin_zero_in(gate[0]), .ext_irq_pin_one_in(gate[1]), .count_pin_zero_in(pins[0]),
    .count_pin_one_in(pins[1]), .timer_two_count_pin_in(pins[2]), .trigger_pin_in(pins[3]),
    .vector_ack_zero_in, .vector_ack_one_in, .overflow_flag_zero_out, .overflow_flag_one_out,
    .timer_two_overflow_flag_out, .timer_two_external_flag_out, .timer_one_overflow_pulse_out);
  dlt_pin_model model (.clk_sys_in, .rst_n_in, .gate_req_in(gate_req), .fall_req_in(fall_req),
    .gate_out(gate), .pins_out(pins));
  //****************************************************************
  // Clock, hang guard and bus tasks
  //****************************************************************
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  // Setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= {2'b00, idx, 2'b00};
    pwdata_in <= {24'h000000, d};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    rdv  = prdata_out;
    errv = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, rdv);
  endtask
  // Pin falls, then settle time
  task automatic pulse(input logic [3:0] m);
    fall_req <= m;
    @(posedge clk_sys_in);
    fall_req <= 4'h0;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //****************************************************************
  // Main sequence
  //****************************************************************
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (rows[i]) begin
      wr(rows[i][24:17], rows[i][16:9]);
      chk("write error", 32'(rows[i][0]), 32'(errv));
      rchk("read back", rows[i][24:17], 32'(rows[i][8:1]));
      chk("read error", 32'(rows[i][0]), 32'(errv));
    end
    $display("register rows done");
    // Timer zero as a 13-bit event counter
    wr(`DLT_IDX_TMODE, 8'h04);
    wr(`DLT_IDX_T0LO, 8'h1F);
    wr(`DLT_IDX_T0HI, 8'h41);
    wr(`DLT_IDX_TCTL, 8'h10);
    pulse(4'h1);
    rchk("t0hi", `DLT_IDX_T0HI, 32'h42);
    rchk("t0lo", `DLT_IDX_T0LO, 32'h00);
    wr(`DLT_IDX_T0HI, 8'hFF);
    wr(`DLT_IDX_T0LO, 8'h1F);
    pulse(4'h1);
    chk("flag0", 32'h1, 32'(overflow_flag_zero_out));
    rchk("t0hi", `DLT_IDX_T0HI, 32'h00);
    vector_ack_zero_in <= 1'b1;
    @(posedge clk_sys_in);
    vector_ack_zero_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk("flag0", 32'h0, 32'(overflow_flag_zero_out));
    wr(`DLT_IDX_TCTL, 8'h00);
    pulse(4'h1);
    rchk("t0lo", `DLT_IDX_T0LO, 32'h00);
    // Gated 16-bit counter, then 8-bit reload
    wr(`DLT_IDX_TMODE, 8'h0D);
    wr(`DLT_IDX_TCTL, 8'h10);
    pulse(4'h1);
    rchk("t0lo", `DLT_IDX_T0LO, 32'h00);
    gate_req <= 2'b01;
    pulse(4'h1);
    rchk("t0lo", `DLT_IDX_T0LO, 32'h01);
    wr(`DLT_IDX_T0LO, 8'hFF);
    wr(`DLT_IDX_T0HI, 8'hFF);
    pulse(4'h1);
    chk("flag0", 32'h1, 32'(overflow_flag_zero_out));
    rchk("t0hi", `DLT_IDX_T0HI, 32'h00);
    wr(`DLT_IDX_TMODE, 8'h06);
    wr(`DLT_IDX_T0HI, 8'hC8);
    wr(`DLT_IDX_T0LO, 8'hFF);
    pulse(4'h1);
    rchk("t0lo", `DLT_IDX_T0LO, 32'hC8);
    // Split timer zero; timer one split holds its count
    wr(`DLT_IDX_TMODE, 8'h77);
    wr(`DLT_IDX_T0LO, 8'hFF);
    wr(`DLT_IDX_T0HI, 8'hFF);
    wr(`DLT_IDX_T1LO, 8'h33);
    wr(`DLT_IDX_TCTL, 8'h50);
    pulse(4'h3);
    rchk("tctl", `DLT_IDX_TCTL, 32'hF0);
    rchk("t1lo", `DLT_IDX_T1LO, 32'h33);
    $display("timers zero and one done");
    // Timer two capture, reload, disabled trigger, stop, routing, forcing
    wr(`DLT_IDX_T2LO, 8'h34);
    wr(`DLT_IDX_T2HI, 8'h12);
    wr(`DLT_IDX_T2CTL, 8'h0F);
    pulse(4'h8);
    rchk("caplo", `DLT_IDX_CAPLO, 32'h34);
    rchk("caphi", `DLT_IDX_CAPHI, 32'h12);
    chk("ext", 32'h1, 32'(timer_two_external_flag_out));
    pulse(4'h4);
    rchk("t2lo", `DLT_IDX_T2LO, 32'h35);
    wr(`DLT_IDX_CAPLO, 8'h78);
    wr(`DLT_IDX_CAPHI, 8'h56);
    wr(`DLT_IDX_T2LO, 8'hFF);
    wr(`DLT_IDX_T2HI, 8'hFF);
    wr(`DLT_IDX_T2CTL, 8'h0E);
    pulse(4'h4);
    rchk("t2hi", `DLT_IDX_T2HI, 32'h56);
    chk("ovf", 32'h1, 32'(timer_two_overflow_flag_out));
    wr(`DLT_IDX_T2LO, 8'h00);
    pulse(4'h8);
    rchk("t2lo", `DLT_IDX_T2LO, 32'h78);
    chk("ext", 32'h1, 32'(timer_two_external_flag_out));
    wr(`DLT_IDX_T2CTL, 8'h06);
    wr(`DLT_IDX_T2LO, 8'h00);
    pulse(4'h8);
    rchk("t2lo", `DLT_IDX_T2LO, 32'h00);
    chk("ext", 32'h0, 32'(timer_two_external_flag_out));
    wr(`DLT_IDX_T2CTL, 8'h02);
    pulse(4'h4);
    rchk("t2lo", `DLT_IDX_T2LO, 32'h00);
    wr(`DLT_IDX_T2LO, 8'hFF);
    wr(`DLT_IDX_T2HI, 8'hFF);
    wr(`DLT_IDX_T2CTL, 8'h17);
    pulse(4'h4);
    rchk("t2hi", `DLT_IDX_T2HI, 32'h56);
    chk("ovf", 32'h0, 32'(timer_two_overflow_flag_out));
    wr(`DLT_IDX_T2CTL, 8'hC0);
    chk("ovf", 32'h1, 32'(timer_two_overflow_flag_out));
    chk("ext", 32'h1, 32'(timer_two_external_flag_out));
    wr(`DLT_IDX_TCTL, 8'h00);
    $display("timer two done");
    finish_test();
  end
endmodule
`default_nettype wire
